// ==== logic/dms_supervisor.sv ====
// Supervisor: indicators, modes, override, trip clear, shutdown, groups
// Operation
// - Two open-drain active-low indicator outputs
// - Fault indicator low while any error
// - Spare indicator active low, source configurable
// - Modes switch targets after delays automatically
// - Mode started by host or pins
// - Each action says on or off
// - Action delays in 100 ms steps
// - Initial mode runs right after reset
// - Initial mode enable gates boot run
// - Override by host or low pin
// - Override masks trips except short circuit
// - Override masks voltage and temperature errors
// - Trip clear pin falling edge clears all
// - Host trip clear does the same
// - Shutdown turns every output off now
// - No switch-on while shutdown active
// - Shutdown by host or low pin
// - Configuration held in external nonvolatile store
// - Up to seven equal-rating channel groups
// - Group acts as one logical channel
// - Per-target trip limits, shared env limits
// - Discrete inputs active low, idle high
`timescale 1ns/100ps
module dms_supervisor
    import dms_pkg::*;
#(
    parameter int DEB_COUNT  = DEB_CYC,      // Debounce cycles
    parameter int STEP_COUNT = DLY_STEP_CYC  // Cycles per delay step
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    // Discrete pins, active low
    input  wire logic [MODE_W-1:0]              mode_sel_n,
    input  wire logic                           trip_clear_n,
    input  wire logic                           shutdown_n,
    input  wire logic                           override_n,
    // Host commands, one-cycle pulses or levels
    input  wire logic                           host_mode_go,
    input  wire logic [MODE_W-1:0]              host_mode_idx,
    input  wire logic                           host_trip_clear,
    input  wire logic                           host_shutdown,
    input  wire logic                           host_override,
    input  wire logic                           host_sw_valid,
    input  wire logic [TGT_W-1:0]               host_sw_tgt,
    input  wire logic                           host_sw_on,
    // Configuration mirrored from nonvolatile store
    input  wire logic                           init_en,
    input  wire logic [MODE_W-1:0]              init_mode,
    input  wire logic [NUM_MODE*NUM_STEP*TGT_W-1:0] mode_tgt,
    input  wire logic [NUM_MODE*NUM_STEP-1:0]   mode_act,
    input  wire logic [NUM_MODE*NUM_STEP*DLY_W-1:0] mode_dly,
    input  wire logic [NUM_MODE*NUM_STEP-1:0]   mode_use,
    input  wire logic [NUM_CH*GRP_W-1:0]        ch_group,
    // Protection causes from measuring logic
    input  wire logic [NUM_CH-1:0]              ch_short,
    input  wire logic [NUM_CH-1:0]              ch_i2t,
    input  wire logic [NUM_CH-1:0]              ch_inst,
    input  wire logic                           env_err,
    input  wire logic                           other_err,
    input  wire logic                           spare_src,
    // Outputs
    output logic [NUM_CH-1:0]                   ch_on,
    output logic [NUM_CH-1:0]                   ch_tripped,
    output logic                                override_act,
    output logic                                shutdown_act,
    output logic                                seq_busy,
    output logic                                fault_o,
    output logic                                fault_oe,
    output logic                                spare_o,
    output logic                                spare_oe
);
    // ========================================
    // Input filtering
    logic [MODE_W-1:0] mode_f_n;             // Filtered mode pins
    logic              clr_f_n;              // Filtered trip clear
    logic              sd_f_n;               // Filtered shutdown
    logic              ov_f_n;               // Filtered override
    logic              clr_d_reg;            // Previous trip clear level
    logic [MODE_W-1:0] mode_d_reg;           // Previous mode pins
    genvar gi;
    generate
        for (gi = 0; gi < MODE_W + 3; gi++) begin : g_deb
            logic pin;
            logic lvl;
            if (gi < MODE_W) begin : g_m
                assign pin = mode_sel_n[gi];
                assign mode_f_n[gi] = lvl;
            end else if (gi == MODE_W) begin : g_c
                assign pin = trip_clear_n;
                assign clr_f_n = lvl;
            end else if (gi == MODE_W + 1) begin : g_s
                assign pin = shutdown_n;
                assign sd_f_n = lvl;
            end else begin : g_o
                assign pin = override_n;
                assign ov_f_n = lvl;
            end
            dms_debounce #(.DEB_COUNT(DEB_COUNT)) u_deb (
                .clk     (clk),
                .rst     (rst),
                .pin_n   (pin),
                .level_n (lvl)
            );
        end
    endgenerate

    // ========================================
    // Decoded controls
    // Falling edge of clear pin
    wire clr_edge = clr_d_reg & ~clr_f_n;
    wire clr_all  = clr_edge | host_trip_clear;
    wire sd_now   = ~sd_f_n | host_shutdown;
    wire ov_now   = ~ov_f_n | host_override;
    // Pin mode request on new nonzero code
    wire [MODE_W-1:0] pin_code = ~mode_f_n;
    wire pin_go   = (pin_code != mode_d_reg) && (pin_code != '0);

    // ========================================
    // Group mapping: a target index below NUM_CH is a channel, NUM_CH to NUM_CH + NUM_GRP - 1 a group, the rest none
    logic [NUM_CH-1:0] tgt_mask [0:(1<<TGT_W)-1];  // Channels hit by each target
    generate
        for (gi = 0; gi < (1 << TGT_W); gi++) begin : g_tgt
            genvar ci;
            for (ci = 0; ci < NUM_CH; ci++) begin : g_ch
                wire [GRP_W-1:0] gid = ch_group[ci*GRP_W +: GRP_W];
                if (gi < NUM_CH) begin : g_single
                    assign tgt_mask[gi][ci] = (gi == ci) && (gid == '0);
                end else if (gi <= NUM_CH + NUM_GRP - 1) begin : g_grp
                    assign tgt_mask[gi][ci] = (gid == GRP_W'(gi - NUM_CH + 1));
                end else begin : g_none
                    assign tgt_mask[gi][ci] = 1'b0;
                end
            end
        end
    endgenerate

    // ========================================
    // Protection
    // Only short circuit trips under override
    wire [NUM_CH-1:0] trip_raw = ch_short | (override_act ? '0 : (ch_i2t | ch_inst));
    logic [NUM_CH-1:0] trip_grp;             // Trip spread across group
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_trip
            wire [GRP_W-1:0] gid = ch_group[gi*GRP_W +: GRP_W];
            wire [TGT_W-1:0] t = (gid == '0) ? TGT_W'(gi) : TGT_W'(NUM_CH - 1 + gid);
            assign trip_grp[gi] = |(trip_raw & tgt_mask[t]);
        end
    endgenerate
    // Clear wins for latched trips, fresh causes re-set
    wire [NUM_CH-1:0] trip_next = (clr_all ? '0 : ch_tripped) | trip_grp;
    wire err_any = (|ch_tripped) | other_err | (env_err & ~override_act);

    // ========================================
    // Sequencer
    dms_seq_t           st_reg;              // Sequencer state
    logic [MODE_W-1:0]  mode_reg;            // Running mode
    logic [STEP_W-1:0]  step_reg;            // Current action
    logic [DLY_W-1:0]   dly_reg;             // Remaining 100 ms steps
    logic [TICK_W-1:0]  tick_reg;            // Cycles within one step
    logic               boot_reg;            // Boot check pending
    wire  [3:0]         sidx = {mode_reg, step_reg};
    wire  [TGT_W-1:0]   s_tgt = mode_tgt[sidx*TGT_W +: TGT_W];
    wire                s_on  = mode_act[sidx];
    wire  [DLY_W-1:0]   s_dly = mode_dly[sidx*DLY_W +: DLY_W];
    wire                s_use = mode_use[sidx];
    wire  tick_end = (tick_reg == TICK_W'(STEP_COUNT - 1));
    wire  last     = (step_reg == STEP_W'(NUM_STEP - 1));
    wire  boot_go  = boot_reg & init_en;
    wire  start    = boot_go | host_mode_go | pin_go;
    wire  [MODE_W-1:0] start_mode = boot_go ? init_mode :
                                    (host_mode_go ? host_mode_idx : pin_code);
    wire  seq_fire = (st_reg == DMS_DO) && s_use;

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg   <= DMS_IDLE;
            mode_reg <= '0;
            step_reg <= '0;
            dly_reg  <= '0;
            tick_reg <= '0;
            boot_reg <= 1'b1;
        end else begin
            boot_reg <= 1'b0;
            unique case (st_reg)
                DMS_IDLE: begin
                    // New run
                    if (start) begin
                        mode_reg <= start_mode;
                        step_reg <= '0;
                        dly_reg  <= mode_dly[{start_mode, 2'b00}*DLY_W +: DLY_W];
                        tick_reg <= '0;
                        st_reg   <= DMS_WAIT;
                    end
                end
                DMS_WAIT: begin
                    // Count down step delay
                    if (dly_reg == '0) begin
                        st_reg <= DMS_DO;
                    end else begin
                        tick_reg <= tick_end ? '0 : tick_reg + 1'b1;
                        if (tick_end) begin
                            dly_reg <= dly_reg - 1'b1;
                        end
                    end
                end
                DMS_DO: begin
                    // Advance to next action or finish
                    if (last) begin
                        st_reg <= DMS_IDLE;
                    end else begin
                        step_reg <= step_reg + 1'b1;
                        dly_reg  <= mode_dly[{mode_reg, step_reg + 2'b01}*DLY_W +: DLY_W];
                        tick_reg <= '0;
                        st_reg   <= DMS_WAIT;
                    end
                end
            endcase
        end
    end

    // ========================================
    // Output switching
    // Action direction per entry
    wire [NUM_CH-1:0] seq_mask = seq_fire ? tgt_mask[s_tgt] : '0;
    wire [NUM_CH-1:0] host_mask = host_sw_valid ? tgt_mask[host_sw_tgt] : '0;
    wire [NUM_CH-1:0] on_req  = (seq_fire && s_on ? seq_mask : '0) |
                                (host_sw_on ? host_mask : '0);
    wire [NUM_CH-1:0] off_req = (seq_fire && !s_on ? seq_mask : '0) |
                                (!host_sw_on ? host_mask : '0);
    // Switch-on blocked by shutdown or trip
    wire [NUM_CH-1:0] on_next = sd_now ? CH_RST :
                                ((ch_on & ~off_req) | on_req) & ~trip_grp & ~ch_tripped;

    // Channel, trip and status registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ch_on        <= CH_RST;
            ch_tripped   <= CH_RST;
            clr_d_reg    <= 1'b1;
            mode_d_reg   <= '0;
            override_act <= 1'b0;
            shutdown_act <= 1'b0;
            seq_busy     <= 1'b0;
            fault_o      <= 1'b0;
            fault_oe     <= 1'b0;
            spare_o      <= 1'b0;
            spare_oe     <= 1'b0;
        end else begin
            ch_on        <= on_next;
            ch_tripped   <= trip_next;
            clr_d_reg    <= clr_f_n;
            mode_d_reg   <= pin_code;
            override_act <= ov_now;
            shutdown_act <= sd_now;
            seq_busy     <= (st_reg != DMS_IDLE) | start;
            fault_oe     <= err_any;
            spare_oe     <= spare_src;
        end
    end
    // Settings come from the nonvolatile mirror ports

    // ========================================
    // Checks
    // Outputs off after shutdown
    a_shutdown_off: assert property (@(posedge clk) disable iff (rst)
        sd_now |=> (ch_on == '0))
        else $error("output on after shutdown");
    a_shutdown_lock: assert property (@(posedge clk) disable iff (rst)
        shutdown_act && $past(sd_now) |-> ((ch_on & ~$past(ch_on)) == '0))
        else $error("output rose in shutdown");
    a_trip_clear: assert property (@(posedge clk) disable iff (rst)
        clr_edge && trip_grp == '0 |=> ch_tripped == '0)
        else $error("trip clear missed");
    a_override_mask: assert property (@(posedge clk) disable iff (rst)
        override_act && ch_short == '0 && ch_tripped == '0 && !clr_all |=>
        ch_tripped == '0)
        else $error("non-short trip in override");
    a_fault_follow: assert property (@(posedge clk) disable iff (rst)
        err_any |=> fault_oe && !fault_o)
        else $error("fault indicator not low");
    a_env_mask: assert property (@(posedge clk) disable iff (rst)
        override_act && !other_err && ch_tripped == '0 |=> !fault_oe)
        else $error("env error not masked");
    a_boot_start: assert property (@(posedge clk)
        $past(rst) && !rst && init_en |=> seq_busy)
        else $error("initial mode not started");
    sequence s_wait_step;
        (st_reg == DMS_WAIT && dly_reg == 8'h01 && tick_reg == '0);
    endsequence
    a_step_len: assert property (@(posedge clk) disable iff (rst)
        s_wait_step ##1 (st_reg == DMS_WAIT) |-> (dly_reg == 8'h01))
        else $error("delay step too short");
    // Each wait loads its own step delay
    a_dly_load: assert property (@(posedge clk) disable iff (rst)
        st_reg == DMS_WAIT && $past(st_reg) != DMS_WAIT |-> dly_reg == s_dly)
        else $error("step delay not loaded");
    a_short_trip: assert property (@(posedge clk) disable iff (rst)
        ch_short != '0 |=> (ch_tripped & $past(ch_short)) == $past(ch_short))
        else $error("short circuit not tripped");
    a_trip_off: assert property (@(posedge clk) disable iff (rst)
        (ch_on & ch_tripped) == '0)
        else $error("tripped channel on");
    a_host_clear: assert property (@(posedge clk) disable iff (rst)
        host_trip_clear && trip_grp == '0 |=> ch_tripped == '0)
        else $error("host trip clear missed");
    a_override_pin: assert property (@(posedge clk) disable iff (rst)
        !ov_f_n |=> override_act)
        else $error("override pin ignored");
    a_spare_drive: assert property (@(posedge clk) disable iff (rst)
        spare_src |=> spare_oe && !spare_o)
        else $error("spare indicator not low");
endmodule // dms_supervisor

// ==== logic/dms_pkg.sv ====
// Shared constants and types for the discrete mode and protection supervisor
package dms_pkg;
    // ========================================
    // Sizes
    localparam int NUM_CH           = 16;              // Output channels
    localparam int NUM_GRP          = 7;               // Paralleled channel groups
    localparam int NUM_MODE         = 4;               // Selectable modes
    localparam int NUM_STEP         = 4;               // Actions per mode
    localparam int DLY_W            = 8;               // Delay field width, 100 ms units
    localparam int TGT_W            = 5;               // Target index, channels then groups
    localparam int GRP_W            = 3;               // Group id, 0 means ungrouped
    localparam int MODE_W           = 2;               // Mode index width
    localparam int STEP_W           = 2;               // Step index width
    localparam int TICK_W           = 24;              // Tick counter width
    // ========================================
    // Timing
    localparam int CLK_PERIOD_NS    = 10;              // 100 MHz clock
    localparam int DLY_STEP_MS      = 100;             // Delay resolution
    localparam int DLY_STEP_CYC     = DLY_STEP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int DEB_US           = 1000;            // Debounce settle time
    localparam int DEB_CYC          = DEB_US * 1000 / CLK_PERIOD_NS;
    localparam int DEB_W            = 17;              // Debounce counter width
    // ========================================
    // Reset values and fields
    localparam logic [NUM_CH-1:0] CH_RST = 16'h0000;   // All outputs off at reset
    localparam int ACT_ON_BIT       = 0;               // Action field: 1 switches on
    // Sequencer states
    typedef enum logic [1:0] {DMS_IDLE, DMS_WAIT, DMS_DO} dms_seq_t;
endpackage

// ==== logic/dms_debounce.sv ====
// Three-stage synchroniser and debounce filter for one discrete input
`timescale 1ns/100ps
module dms_debounce
    import dms_pkg::*;
#(
    parameter int DEB_COUNT = DEB_CYC    // Stable cycles before acceptance
) (
    input  wire logic clk,               // System clock
    input  wire logic rst,               // Synchronous reset
    input  wire logic pin_n,             // Raw active-low pin
    output logic      level_n            // Filtered level
);
    // ========================================
    // Synchroniser
    logic             s1_reg;            // First stage, read only by s2
    logic             s2_reg;            // Second stage
    logic             s3_reg;            // Third stage
    logic [DEB_W-1:0] cnt_reg;           // Stability counter
    logic [DEB_W-1:0] cnt_next;          // Next count
    wire              agree = (s2_reg == s3_reg);
    wire              differ = agree && (s3_reg != level_n);
    wire              done = (cnt_reg >= DEB_W'(DEB_COUNT - 1));

    assign cnt_next = differ ? (done ? '0 : cnt_reg + 1'b1) : '0;

    // Pipeline, pulled-up inactive level at reset
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg  <= 1'b1;
            s2_reg  <= 1'b1;
            s3_reg  <= 1'b1;
            cnt_reg <= '0;
            level_n <= 1'b1;
        end else begin
            s1_reg  <= pin_n;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            cnt_reg <= cnt_next;
            // Accept once stable long enough
            if (differ && done) begin
                level_n <= s3_reg;
            end
        end
    end
endmodule // dms_debounce

// ==== sim/dms_host_model.sv ====
// Host side model: pulled-up discrete contacts and open-drain indicator wires
`timescale 1ns/100ps
module dms_host_model
    import dms_pkg::*;
(
    input  wire logic [MODE_W-1:0] mode_req,     // Mode code to close, 0 none
    input  wire logic              clr_req,      // Close trip clear contact
    input  wire logic              sd_req,       // Close shutdown contact
    input  wire logic              ovr_req,      // Close override contact
    input  wire logic              fault_o,      // Fault driver level
    input  wire logic              fault_oe,     // Fault driver enable
    input  wire logic              spare_o,      // Spare driver level
    input  wire logic              spare_oe,     // Spare driver enable
    output logic [MODE_W-1:0]      mode_sel_n,   // Mode contacts
    output logic                   trip_clear_n, // Trip clear contact
    output logic                   shutdown_n,   // Shutdown contact
    output logic                   override_n,   // Override contact
    output logic                   fault_line,   // Pulled-up fault wire
    output logic                   spare_line    // Pulled-up spare wire
);
    // ========================================
    // Contacts pull to return when closed, float high when open
    // mode select contacts
    assign mode_sel_n   = ~mode_req;
    assign override_n   = ~ovr_req;
    assign shutdown_n   = ~sd_req;
    assign trip_clear_n = ~clr_req;
    assign fault_line   = fault_oe ? fault_o : 1'b1;
    assign spare_line   = spare_oe ? spare_o : 1'b1;
endmodule // dms_host_model

// ==== sim/testbench.sv ====
// Self-checking bench for the supervisor
`timescale 1ns/100ps
module testbench;
    import dms_pkg::*;
    // ========================================
    // Signals
    localparam int DEB = 4;                        // Short debounce
    localparam int STEP = 8;                       // Short delay step
    localparam int MS = NUM_MODE * NUM_STEP;       // Mode table entries
    logic                    clk = 1'b0, rst = 1'b1, host_mode_go = 1'b0;
    logic                    host_trip_clear = 1'b0, host_shutdown = 1'b0;
    logic                    host_override = 1'b0, host_sw_valid = 1'b0, host_sw_on = 1'b0;
    logic                    init_en = 1'b0, env_err = 1'b0, other_err = 1'b0;
    logic                    spare_src = 1'b0, clr_req = 1'b0, sd_req = 1'b0, ovr_req = 1'b0;
    logic [MODE_W-1:0]       host_mode_idx = 2'h0, init_mode = 2'h0, mode_req = 2'h0;
    logic [TGT_W-1:0]        host_sw_tgt = 5'h00;
    logic [MS*TGT_W-1:0]     mode_tgt = '0;
    logic [MS-1:0]           mode_act = '0, mode_use = '0;
    logic [MS*DLY_W-1:0]     mode_dly = '0;
    logic [NUM_CH*GRP_W-1:0] ch_group = '0;
    logic [NUM_CH-1:0]       ch_short = '0, ch_i2t = '0, ch_inst = '0;
    logic [NUM_CH-1:0]       ch_on, ch_tripped, exp_on;
    logic                    override_act, shutdown_act, seq_busy, fault_o, fault_oe;
    logic                    spare_o, spare_oe, fault_line, spare_line;
    logic [MODE_W-1:0]       mode_sel_n;
    logic                    trip_clear_n, shutdown_n, override_n;
    logic [31:0]             seed = 32'hed99fca1;   // Random state
    int                      fails = 0, check_count = 0, c;
    // Free-running clock
    always #5 clk = ~clk;
    dms_supervisor #(.DEB_COUNT(DEB), .STEP_COUNT(STEP)) u_dut (
        .clk, .rst, .mode_sel_n, .trip_clear_n, .shutdown_n, .override_n, .host_mode_go,
        .host_mode_idx, .host_trip_clear, .host_shutdown, .host_override, .host_sw_valid,
        .host_sw_tgt, .host_sw_on, .init_en, .init_mode, .mode_tgt, .mode_act, .mode_dly,
        .mode_use, .ch_group, .ch_short, .ch_i2t, .ch_inst, .env_err, .other_err,
        .spare_src, .ch_on, .ch_tripped, .override_act, .shutdown_act, .seq_busy,
        .fault_o, .fault_oe, .spare_o, .spare_oe);
    dms_host_model u_host (.mode_req, .clr_req, .sd_req, .ovr_req, .fault_o, .fault_oe,
        .spare_o, .spare_oe, .mode_sel_n, .trip_clear_n, .shutdown_n, .override_n,
        .fault_line, .spare_line);
    // ========================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Channels belonging to one group
    function automatic logic [NUM_CH-1:0] grp_mask(input int g);
        for (int i = 0; i < NUM_CH; i++) grp_mask[i] = (ch_group[i*GRP_W +: GRP_W] == g);
    endfunction
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic set_step(input int m, s, tgt, input logic on, input int d);
        int i;
        i = m * NUM_STEP + s;
        mode_tgt[i*TGT_W +: TGT_W] = tgt[TGT_W-1:0];
        mode_act[i] = on;
        mode_dly[i*DLY_W +: DLY_W] = d[DLY_W-1:0];
        mode_use[i] = 1'b1;
    endtask
    // One-cycle host switch request
    task automatic sw(input int tgt, input logic on);
        @(negedge clk);
        host_sw_valid = 1'b1;
        host_sw_tgt = tgt[TGT_W-1:0];
        host_sw_on = on;
        @(negedge clk);
        host_sw_valid = 1'b0;
        cyc(2);
    endtask
    task automatic mode_go(input int m);
        @(negedge clk);
        host_mode_go = 1'b1;
        host_mode_idx = m[MODE_W-1:0];
        @(negedge clk);
        host_mode_go = 1'b0;
    endtask
    // Bounded wait on one output bit
    task automatic wait_on(input int ch, input logic v, input int lim);
        int n;
        n = 0;
        while (ch_on[ch] !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        check("ch_on bit", 16'(v), 16'(ch_on[ch]));
        if (n >= lim) conclude();
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (seq_busy !== 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check("seq_busy", 16'h0000, 16'(seq_busy));
        if (n >= 300) conclude();
    endtask
    task automatic do_reset(input logic en);
        @(negedge clk);
        init_en = en;
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
    endtask
    // ========================================
    // Main sequence
    initial begin
        set_step(0, 0, 3, 1'b1, 2);
        set_step(1, 0, 5, 1'b1, 1);
        set_step(2, 0, 5, 1'b1, 1);
        set_step(3, 0, 5, 1'b0, 0);
        ch_group[14*GRP_W +: GRP_W] = 3'h1;
        ch_group[15*GRP_W +: GRP_W] = 3'h1;
        do_reset(1'b0);
        cyc(30);
        check("ch_on no boot", 16'h0000, ch_on);
        do_reset(1'b1);
        cyc(10);
        check("ch_on early", 16'h0000, ch_on);
        wait_on(3, 1'b1, 30);
        exp_on = 16'h0008;
        wait_idle();
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            c = int'(seed[3:0]) % 14;
            sw(c, seed[4]);
            exp_on[c] = seed[4];
            check("ch_on host", exp_on, ch_on);
        end
        sw(16, 1'b1);
        exp_on |= grp_mask(1);
        check("ch_on group", exp_on, ch_on);
        sw(14, 1'b0);
        check("ch_on member", exp_on, ch_on);
        sw(1, 1'b1);
        exp_on[1] = 1'b1;
        host_override = 1'b1;
        cyc(3);
        check("override_act", 16'h0001, 16'(override_act));
        ch_i2t[1] = 1'b1;
        env_err = 1'b1;
        cyc(3);
        check("ch_on override", exp_on, ch_on);
        check("fault_oe override", 16'h0000, 16'(fault_oe));
        ch_short[1] = 1'b1;
        cyc(3);
        exp_on[1] = 1'b0;
        check("ch_on short", exp_on, ch_on);
        ch_short[1] = 1'b0;
        host_override = 1'b0;
        cyc(3);
        check("ch_tripped", 16'h0002, ch_tripped);
        check("fault_line", 16'h0000, 16'(fault_line));
        ch_i2t[1] = 1'b0;
        env_err = 1'b0;
        clr_req = 1'b1;
        cyc(12);
        check("ch_tripped pin", 16'h0000, ch_tripped);
        check("fault_line idle", 16'h0001, 16'(fault_line));
        clr_req = 1'b0;
        other_err = 1'b1;
        cyc(3);
        check("fault_oe other", 16'h0001, 16'(fault_oe));
        other_err = 1'b0;
        ovr_req = 1'b1;
        cyc(12);
        check("override pin", 16'h0001, 16'(override_act));
        ovr_req = 1'b0;
        cyc(12);
        check("override off", 16'h0000, 16'(override_act));
        c = int'(seed[7:4]) % 14;
        ch_inst[c] = 1'b1;
        cyc(3);
        ch_inst[c] = 1'b0;
        exp_on[c] = 1'b0;
        check("inst trip", 16'h0001 << c, ch_tripped);
        @(negedge clk);
        host_trip_clear = 1'b1;
        @(negedge clk);
        host_trip_clear = 1'b0;
        cyc(2);
        check("ch_tripped host", 16'h0000, ch_tripped);
        spare_src = 1'b1;
        cyc(3);
        check("spare_line", 16'h0000, 16'(spare_line));
        spare_src = 1'b0;
        mode_req = 2'h2;
        cyc(12);
        mode_req = 2'h0;
        wait_on(5, 1'b1, 60);
        exp_on[5] = 1'b1;
        wait_idle();
        mode_go(3);
        wait_on(5, 1'b0, 40);
        exp_on[5] = 1'b0;
        check("ch_on modes", exp_on, ch_on);
        wait_idle();
        sd_req = 1'b1;
        cyc(12);
        check("ch_on shutdown", 16'h0000, ch_on);
        sw(0, 1'b1);
        check("ch_on refused", 16'h0000, ch_on);
        mode_go(1);
        cyc(30);
        check("ch_on mode blocked", 16'h0000, ch_on);
        sd_req = 1'b0;
        cyc(12);
        host_shutdown = 1'b1;
        cyc(3);
        check("shutdown_act", 16'h0001, 16'(shutdown_act));
        host_shutdown = 1'b0;
        wait_idle();
        conclude();
    end
endmodule // testbench
